// ---- verilog/start_cmd_pkg.sv ----
// constants for the start/stop/direction command source selection block
package start_cmd_pkg;
    // Avalon-MM register word addresses (byte address = 4 * word)
    localparam logic [3:0] ADDR_LOC_ONE_MODE = 4'h0;
    localparam logic [3:0] ADDR_LOC_ONE_TRIG = 4'h1;
    localparam logic [3:0] ADDR_LOC_ONE_SRC_A = 4'h2;
    localparam logic [3:0] ADDR_LOC_ONE_SRC_B = 4'h3;
    localparam logic [3:0] ADDR_LOC_ONE_SRC_C = 4'h4;
    localparam logic [3:0] ADDR_LOC_TWO_MODE = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    // command modes
    localparam logic [4:0] MODE_NONE = 5'h00;
    localparam logic [4:0] MODE_START = 5'h01;
    localparam logic [4:0] MODE_START_DIR = 5'h02;
    localparam logic [4:0] MODE_FWD_REV = 5'h03;
    localparam logic [4:0] MODE_FIELDBUS = 5'h0E;
    // trigger kinds
    localparam logic TRIG_EDGE = 1'b0;
    localparam logic TRIG_LEVEL = 1'b1;
    // source selector codes
    localparam logic [4:0] SRC_OFF = 5'h00;
    localparam logic [4:0] SRC_ON = 5'h01;
    localparam logic [4:0] SRC_DI_FIRST = 5'h02;
    localparam logic [4:0] SRC_DI_LAST = 5'h07;
    localparam logic [4:0] SRC_TIMED_FIRST = 5'h12;
    localparam logic [4:0] SRC_TIMED_LAST = 5'h14;
    localparam logic [4:0] SRC_SUPV_FIRST = 5'h18;
    localparam logic [4:0] SRC_SUPV_LAST = 5'h1A;
    // reset values
    localparam logic [4:0] RST_LOC_ONE_MODE = MODE_START_DIR;
    localparam logic RST_LOC_ONE_TRIG = TRIG_LEVEL;
    localparam logic [4:0] RST_SRC_A = SRC_DI_FIRST;
    localparam logic [4:0] RST_SRC_B = SRC_OFF;
    localparam logic [4:0] RST_SRC_C = SRC_OFF;
    localparam logic [4:0] RST_LOC_TWO_MODE = MODE_NONE;
    // status bit positions
    localparam int STAT_START = 0;
    localparam int STAT_REVERSE = 1;
    localparam int STAT_FB_SEL = 2;
endpackage : start_cmd_pkg

// ---- verilog/start_cmd_select.sv ----
// location-one start/stop/direction command source selection with register slave
module start_cmd_select (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [5:0] delayed_input_word,
    input wire logic [2:0] timed_status,
    input wire logic [2:0] supv_status,
    input wire logic fb_start,
    input wire logic fb_reverse,
    output logic run_cmd,
    output logic reverse_cmd,
    output logic [4:0] loc_two_command_mode
);
    logic [4:0] loc_one_command_mode_q;
    logic loc_one_trigger_kind_q;
    logic [4:0] loc_one_source_a_q;
    logic [4:0] loc_one_source_b_q;
    logic [4:0] loc_one_source_c_q;
    logic [4:0] loc_two_mode_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [5:0] di_s1_q;
    logic [5:0] di_s2_q;
    logic [2:0] tm_s1_q;
    logic [2:0] tm_s2_q;
    logic [2:0] sv_s1_q;
    logic [2:0] sv_s2_q;
    logic [1:0] fb_s1_q;
    logic [1:0] fb_s2_q;
    logic src_a;
    logic src_b;
    logic src_a_prev_q;
    logic src_b_prev_q;
    logic run_d;
    logic rev_d;
    logic run_q;
    logic rev_q;

    // one wait cycle per access keeps read data registered
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign avs_readdata = rdata_q;
    assign run_cmd = run_q;
    assign reverse_cmd = rev_q;
    assign loc_two_command_mode = loc_two_mode_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
        end else if (clk_en) begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            loc_one_command_mode_q <= start_cmd_pkg::RST_LOC_ONE_MODE;
            loc_one_trigger_kind_q <= start_cmd_pkg::RST_LOC_ONE_TRIG;
            loc_one_source_a_q <= start_cmd_pkg::RST_SRC_A;
            loc_one_source_b_q <= start_cmd_pkg::RST_SRC_B;
            loc_one_source_c_q <= start_cmd_pkg::RST_SRC_C;
            loc_two_mode_q <= start_cmd_pkg::RST_LOC_TWO_MODE;
        // the write lands on the edge that ends the wait, as the master sees it complete
        end else if (clk_en && avs_write && ack_q) begin
            unique case (avs_address)
                start_cmd_pkg::ADDR_LOC_ONE_MODE: loc_one_command_mode_q <= avs_writedata[4:0];
                start_cmd_pkg::ADDR_LOC_ONE_TRIG: loc_one_trigger_kind_q <= avs_writedata[0];
                start_cmd_pkg::ADDR_LOC_ONE_SRC_A: loc_one_source_a_q <= avs_writedata[4:0];
                start_cmd_pkg::ADDR_LOC_ONE_SRC_B: loc_one_source_b_q <= avs_writedata[4:0];
                start_cmd_pkg::ADDR_LOC_ONE_SRC_C: loc_one_source_c_q <= avs_writedata[4:0];
                start_cmd_pkg::ADDR_LOC_TWO_MODE: loc_two_mode_q <= avs_writedata[4:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (clk_en && avs_read && !ack_q) begin
            unique case (avs_address)
                start_cmd_pkg::ADDR_LOC_ONE_MODE: rdata_q <= {27'h0, loc_one_command_mode_q};
                start_cmd_pkg::ADDR_LOC_ONE_TRIG: rdata_q <= {31'h0, loc_one_trigger_kind_q};
                start_cmd_pkg::ADDR_LOC_ONE_SRC_A: rdata_q <= {27'h0, loc_one_source_a_q};
                start_cmd_pkg::ADDR_LOC_ONE_SRC_B: rdata_q <= {27'h0, loc_one_source_b_q};
                start_cmd_pkg::ADDR_LOC_ONE_SRC_C: rdata_q <= {27'h0, loc_one_source_c_q};
                start_cmd_pkg::ADDR_LOC_TWO_MODE: rdata_q <= {27'h0, loc_two_mode_q};
                start_cmd_pkg::ADDR_STATUS: begin
                    rdata_q <= 32'h0000_0000;
                    rdata_q[start_cmd_pkg::STAT_START] <= run_q;
                    rdata_q[start_cmd_pkg::STAT_REVERSE] <= rev_q;
                    rdata_q[start_cmd_pkg::STAT_FB_SEL] <=
                        (loc_one_command_mode_q == start_cmd_pkg::MODE_FIELDBUS);
                end
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // all status bits come from outside this clock, so two stages each
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            di_s1_q <= 6'h00;
            di_s2_q <= 6'h00;
            tm_s1_q <= 3'h0;
            tm_s2_q <= 3'h0;
            sv_s1_q <= 3'h0;
            sv_s2_q <= 3'h0;
            fb_s1_q <= 2'h0;
            fb_s2_q <= 2'h0;
        end else if (clk_en) begin
            di_s1_q <= delayed_input_word;
            di_s2_q <= di_s1_q;
            tm_s1_q <= timed_status;
            tm_s2_q <= tm_s1_q;
            sv_s1_q <= supv_status;
            sv_s2_q <= sv_s1_q;
            fb_s1_q <= {fb_reverse, fb_start};
            fb_s2_q <= fb_s1_q;
        end
    end

    // reserved codes read as constant off
    function automatic logic pick(input logic [4:0] code, input logic [5:0] di,
                                  input logic [2:0] tm, input logic [2:0] sv);
        logic r;
        r = 1'b0;
        if (code == start_cmd_pkg::SRC_ON) begin
            r = 1'b1;
        end else if (code >= start_cmd_pkg::SRC_DI_FIRST && code <= start_cmd_pkg::SRC_DI_LAST) begin
            r = di[3'(code - start_cmd_pkg::SRC_DI_FIRST)];
        end else if (code >= start_cmd_pkg::SRC_TIMED_FIRST &&
                     code <= start_cmd_pkg::SRC_TIMED_LAST) begin
            r = tm[2'(code - start_cmd_pkg::SRC_TIMED_FIRST)];
        end else if (code >= start_cmd_pkg::SRC_SUPV_FIRST &&
                     code <= start_cmd_pkg::SRC_SUPV_LAST) begin
            r = sv[2'(code - start_cmd_pkg::SRC_SUPV_FIRST)];
        end
        return r;
    endfunction

    // source three is selectable but no location-one mode here consumes it
    assign src_a = pick(loc_one_source_a_q, di_s2_q, tm_s2_q, sv_s2_q);
    assign src_b = pick(loc_one_source_b_q, di_s2_q, tm_s2_q, sv_s2_q);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            src_a_prev_q <= 1'b0;
            src_b_prev_q <= 1'b0;
        end else if (clk_en) begin
            src_a_prev_q <= src_a;
            src_b_prev_q <= src_b;
        end
    end

    always_comb begin
        logic edge_mode;
        logic rise_a;
        logic rise_b;
        edge_mode = (loc_one_trigger_kind_q == start_cmd_pkg::TRIG_EDGE);
        rise_a = src_a & ~src_a_prev_q;
        rise_b = src_b & ~src_b_prev_q;
        run_d = run_q;
        rev_d = rev_q;
        unique case (loc_one_command_mode_q)
            start_cmd_pkg::MODE_START: begin
                if (!src_a) begin
                    run_d = 1'b0;
                end else if (!edge_mode || rise_a) begin
                    run_d = 1'b1;
                end
                rev_d = 1'b0;
            end
            start_cmd_pkg::MODE_START_DIR: begin
                if (!src_a) begin
                    run_d = 1'b0;
                end else if (!edge_mode || rise_a) begin
                    run_d = 1'b1;
                end
                rev_d = src_b;
            end
            start_cmd_pkg::MODE_FWD_REV: begin
                if (src_a == src_b) begin
                    run_d = 1'b0;
                end else if (src_a && (!edge_mode || rise_a)) begin
                    run_d = 1'b1;
                    rev_d = 1'b0;
                end else if (src_b && (!edge_mode || rise_b)) begin
                    run_d = 1'b1;
                    rev_d = 1'b1;
                end
            end
            start_cmd_pkg::MODE_FIELDBUS: begin
                // fieldbus start is a level; trigger kind not applied
                run_d = fb_s2_q[0];
                rev_d = fb_s2_q[1];
            end
            default: begin
                run_d = 1'b0;
                rev_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            run_q <= 1'b0;
            rev_q <= 1'b0;
        end else if (clk_en) begin
            run_q <= run_d;
            rev_q <= rev_d;
        end
    end

    a_none_no_run: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && loc_one_command_mode_q == start_cmd_pkg::MODE_NONE) |=> !run_q)
        else $error("run with no command source");
    a_edge_needs_rise: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && !run_q && loc_one_trigger_kind_q == start_cmd_pkg::TRIG_EDGE &&
         (loc_one_command_mode_q == start_cmd_pkg::MODE_START ||
          loc_one_command_mode_q == start_cmd_pkg::MODE_START_DIR) && src_a_prev_q) |=> !run_q)
        else $error("edge start without rising source");
    a_level_starts: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && loc_one_trigger_kind_q == start_cmd_pkg::TRIG_LEVEL &&
         loc_one_command_mode_q == start_cmd_pkg::MODE_START_DIR && src_a) |=> run_q)
        else $error("level start not taken");
    a_dir_follows: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && loc_one_command_mode_q == start_cmd_pkg::MODE_START_DIR) |=>
        (rev_q == $past(src_b)))
        else $error("direction not from source two");
    a_both_stop: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && loc_one_command_mode_q == start_cmd_pkg::MODE_FWD_REV && src_a == src_b)
        |=> !run_q)
        else $error("mode 3 equal sources must stop");
    a_fb_follows: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && loc_one_command_mode_q == start_cmd_pkg::MODE_FIELDBUS) |=>
        (run_q == $past(fb_s2_q[0])))
        else $error("fieldbus start not followed");
    a_const_on: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (loc_one_source_a_q == start_cmd_pkg::SRC_ON) |-> src_a)
        else $error("constant on selector low");
    a_di_route: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (loc_one_source_b_q == start_cmd_pkg::SRC_DI_LAST) |-> (src_b == di_s2_q[5]))
        else $error("last input code misrouted");
    a_tm_route: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (loc_one_source_a_q == start_cmd_pkg::SRC_TIMED_FIRST) |-> (src_a == tm_s2_q[0]))
        else $error("timed code misrouted");
    a_sv_route: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (loc_one_source_a_q == start_cmd_pkg::SRC_SUPV_LAST) |-> (src_a == sv_s2_q[2]))
        else $error("supervision code misrouted");
    // decisions are checked against the synchronised sources, not the raw pins
    a_fwd_alone: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && loc_one_command_mode_q == start_cmd_pkg::MODE_FWD_REV && src_a && !src_b &&
         loc_one_trigger_kind_q == start_cmd_pkg::TRIG_LEVEL) |=> (run_q && !rev_q))
        else $error("mode 3 forward start missing");
    a_rev_alone: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && loc_one_command_mode_q == start_cmd_pkg::MODE_FWD_REV && !src_a && src_b &&
         loc_one_trigger_kind_q == start_cmd_pkg::TRIG_LEVEL) |=> (run_q && rev_q))
        else $error("mode 3 reverse start missing");
    a_edge_rise_starts: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && loc_one_trigger_kind_q == start_cmd_pkg::TRIG_EDGE &&
         src_a && !src_a_prev_q &&
         (loc_one_command_mode_q == start_cmd_pkg::MODE_START ||
          loc_one_command_mode_q == start_cmd_pkg::MODE_START_DIR)) |=> run_q)
        else $error("edge start not taken on rise");
    a_off_const: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (loc_one_source_b_q == start_cmd_pkg::SRC_OFF) |-> !src_b)
        else $error("constant off selector high");
    a_fb_dir: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (clk_en && loc_one_command_mode_q == start_cmd_pkg::MODE_FIELDBUS) |=>
        (rev_q == $past(fb_s2_q[1])))
        else $error("fieldbus direction not followed");
    c_edge_start: cover property (@(posedge sys_clk) disable iff (!arst_n)
        (loc_one_trigger_kind_q == start_cmd_pkg::TRIG_EDGE && !run_q) ##1 run_q);
    c_frozen_run: cover property (@(posedge sys_clk) disable iff (!arst_n)
        !clk_en && run_q);
    c_fwd_start: cover property (@(posedge sys_clk) disable iff (!arst_n)
        !run_q ##1 run_q && !rev_q);
    c_rev_start: cover property (@(posedge sys_clk) disable iff (!arst_n)
        !run_q ##1 run_q && rev_q);
    c_fb_run: cover property (@(posedge sys_clk) disable iff (!arst_n)
        loc_one_command_mode_q == start_cmd_pkg::MODE_FIELDBUS && run_q);
endmodule // start_cmd_select

// ---- tb/input_source_model.sv ----
// model of the drive side: delayed inputs, timed, supervision and fieldbus levels
module input_source_model (
    input wire logic sys_clk,
    input wire logic [5:0] di_req,
    input wire logic [2:0] tm_req,
    input wire logic [2:0] sv_req,
    input wire logic [1:0] fb_req,
    output logic [5:0] delayed_input_word,
    output logic [2:0] timed_status,
    output logic [2:0] supv_status,
    output logic fb_start,
    output logic fb_reverse
);
    timeunit 1ns;
    timeprecision 100ps;
    // levels move only on a clock edge, as the drive's own status words do
    always_ff @(posedge sys_clk) begin
        delayed_input_word <= di_req;
        timed_status <= tm_req;
        supv_status <= sv_req;
        fb_start <= fb_req[0];
        fb_reverse <= fb_req[1];
    end
endmodule // input_source_model

// ---- tb/start_cmd_select_tb.sv ----
// self-checking bench for the command source selection block
module start_cmd_select_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, arst_n, clk_en, avs_read, avs_write, avs_waitrequest, run_cmd, reverse_cmd;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [5:0] di_req, delayed_input_word;
    logic [2:0] tm_req, sv_req, timed_status, supv_status;
    logic [1:0] fb_req;
    logic fb_start, fb_reverse;
    logic [4:0] loc_two_command_mode;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    start_cmd_select dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .delayed_input_word(delayed_input_word),
        .timed_status(timed_status), .supv_status(supv_status), .fb_start(fb_start),
        .fb_reverse(fb_reverse), .run_cmd(run_cmd), .reverse_cmd(reverse_cmd),
        .loc_two_command_mode(loc_two_command_mode));
    input_source_model far (.sys_clk(sys_clk), .di_req(di_req), .tm_req(tm_req),
        .sv_req(sv_req), .fb_req(fb_req), .delayed_input_word(delayed_input_word),
        .timed_status(timed_status), .supv_status(supv_status), .fb_start(fb_start),
        .fb_reverse(fb_reverse));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // a hung handshake would otherwise stall the run forever
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            stop_test;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    // inputs pass two sync stages before the decision, so allow six edges
    task automatic put(input logic [5:0] di, input logic [2:0] tm, input logic [2:0] sv,
                       input logic [1:0] fb);
        @(posedge sys_clk);
        di_req <= di;
        tm_req <= tm;
        sv_req <= sv;
        fb_req <= fb;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    function automatic logic src_bit(input int c, input logic [5:0] di, input logic [2:0] tm,
                                     input logic [2:0] sv);
        if (c == 1) return 1'b1;
        if (c >= 2 && c <= 7) return di[c - 2];
        if (c >= 18 && c <= 20) return tm[c - 18];
        if (c >= 24 && c <= 26) return sv[c - 24];
        return 1'b0;
    endfunction
    task automatic t_reset;
        logic [4:0] e[6] = '{5'h02, 5'h01, 5'h02, 5'h00, 5'h00, 5'h00};
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 4'(i), 32'h0);
            check(q, 32'(e[i]));
        end
        check(32'(loc_two_command_mode), 32'h0);
        bus(1'b0, 4'hF, 32'h0);
        check(q, 32'h0);
        wr(start_cmd_pkg::ADDR_STATUS, 32'hFF);
        bus(1'b0, start_cmd_pkg::ADDR_STATUS, 32'h0);
        check(q, 32'h0);
        $display("reset values done");
    endtask
    // one selected bit high among zeros, then low among ones, for every code from 0 to 26
    task automatic sweep(input logic [3:0] a, input logic dir);
        logic [5:0] di;
        logic [2:0] tm, sv;
        for (int c = 0; c < 27; c++) begin
            wr(a, 32'(c));
            for (int p = 0; p < 2; p++) begin
                di = (c >= 2 && c <= 7) ? 6'(1 << (c - 2)) : 6'h00;
                tm = (c >= 18 && c <= 20) ? 3'(1 << (c - 18)) : 3'h0;
                sv = (c >= 24 && c <= 26) ? 3'(1 << (c - 24)) : 3'h0;
                if (p == 1) {di, tm, sv} = ~{di, tm, sv};
                put(di, tm, sv, 2'h0);
                check(32'(dir ? reverse_cmd : run_cmd), 32'(src_bit(c, di, tm, sv)));
            end
        end
        $display("selector sweep done");
    endtask
    task automatic t_edge;
        wr(start_cmd_pkg::ADDR_LOC_ONE_MODE, 32'h00);
        wr(start_cmd_pkg::ADDR_LOC_ONE_SRC_A, 32'h02);
        put(6'h01, 3'h0, 3'h0, 2'h0);
        wr(start_cmd_pkg::ADDR_LOC_ONE_TRIG, 32'h00);
        wr(start_cmd_pkg::ADDR_LOC_ONE_MODE, 32'h01);
        put(6'h01, 3'h0, 3'h0, 2'h0);
        check(32'(run_cmd), 32'h0);
        put(6'h00, 3'h0, 3'h0, 2'h0);
        put(6'h01, 3'h0, 3'h0, 2'h0);
        check(32'(run_cmd), 32'h1);
        wr(start_cmd_pkg::ADDR_LOC_ONE_TRIG, 32'h01);
        $display("edge trigger done");
    endtask
    task automatic t_fwd_rev;
        wr(start_cmd_pkg::ADDR_LOC_ONE_MODE, 32'h03);
        wr(start_cmd_pkg::ADDR_LOC_ONE_SRC_B, 32'h03);
        for (int k = 0; k < 4; k++) begin
            put(6'h00, 3'h0, 3'h0, 2'h0);
            put(6'(k), 3'h0, 3'h0, 2'h0);
            check(32'(run_cmd), 32'(k == 1 || k == 2));
            if (k == 1 || k == 2) check(32'(reverse_cmd), 32'(k == 2));
        end
        $display("forward reverse done");
    endtask
    task automatic t_fieldbus;
        wr(start_cmd_pkg::ADDR_LOC_ONE_TRIG, 32'h01);
        wr(start_cmd_pkg::ADDR_LOC_ONE_MODE, 32'h0E);
        wr(start_cmd_pkg::ADDR_LOC_ONE_SRC_A, 32'h01);
        put(6'h3F, 3'h7, 3'h7, 2'h0);
        check(32'(run_cmd), 32'h0);
        put(6'h00, 3'h0, 3'h0, 2'h3);
        check(32'({reverse_cmd, run_cmd}), 32'h3);
        bus(1'b0, start_cmd_pkg::ADDR_STATUS, 32'h0);
        check(q, 32'h7);
        wr(start_cmd_pkg::ADDR_LOC_ONE_TRIG, 32'h00);
        put(6'h00, 3'h0, 3'h0, 2'h1);
        check(32'({reverse_cmd, run_cmd}), 32'h1);
        // with the enable low the fieldbus drop must not reach the run output
        @(posedge sys_clk);
        clk_en <= 1'b0;
        put(6'h00, 3'h0, 3'h0, 2'h0);
        check(32'(run_cmd), 32'h1);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        put(6'h00, 3'h0, 3'h0, 2'h0);
        check(32'(run_cmd), 32'h0);
        $display("fieldbus done");
    endtask
    task automatic t_none;
        wr(start_cmd_pkg::ADDR_LOC_ONE_TRIG, 32'h01);
        wr(start_cmd_pkg::ADDR_LOC_ONE_MODE, 32'h00);
        put(6'h3F, 3'h7, 3'h7, 2'h3);
        check(32'(run_cmd), 32'h0);
        wr(start_cmd_pkg::ADDR_LOC_TWO_MODE, 32'h03);
        bus(1'b0, start_cmd_pkg::ADDR_LOC_TWO_MODE, 32'h0);
        check(q, 32'h3);
        check(32'(loc_two_command_mode), 32'h3);
        $display("no source done");
    endtask
    initial begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        {di_req, tm_req, sv_req, fb_req} = '0;
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_reset;
        wr(start_cmd_pkg::ADDR_LOC_ONE_MODE, 32'h01);
        sweep(start_cmd_pkg::ADDR_LOC_ONE_SRC_A, 1'b0);
        wr(start_cmd_pkg::ADDR_LOC_ONE_MODE, 32'h02);
        wr(start_cmd_pkg::ADDR_LOC_ONE_SRC_A, 32'h01);
        sweep(start_cmd_pkg::ADDR_LOC_ONE_SRC_B, 1'b1);
        t_edge;
        t_fwd_rev;
        t_fieldbus;
        t_none;
        stop_test;
    end
endmodule // start_cmd_select_tb
